// *** hdl/csf_framer.sv ***
// Purpose: build and parse client signal fail pdus for a down client link
// Assumes: byte streams with valid/last; one clock at 25 MHz
// Notes: client link pins are synchronised; config inputs are same-domain
//
// Function
// - sent pdus carry local 3-bit level; received level is reported
// - opcode is 52; received frames match only on opcode 52
// - flags octet holds a 3-bit type and 3-bit period field
// - type codes los 000, fdi 001, rdi 010, dci 011
// - period 100 one second, 110 one minute, 000 invalid
// - tlv offset octet is written as zero
// - pdu ends with one all-zero end tlv octet
// - send only while local and remote endpoints are up
// - remote endpoint ccm loss forces the client port up
// - aggregated client los report timeout is 3.5 transmit intervals
// - only one client interface per endpoint
// - refuse physical port already in an aggregated group
// - non-clear pdu sets remote fault, holds client port down
// - dci pdu or 3.5 period silence clears remote fault
// - client fault starts periodic sending until link returns
// - transmission disabled by default, enabled only by config
`timescale 1ns/1ps
module csf_framer (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration
  input wire logic cfg_tx_en,
  input wire logic [2:0] cfg_level,
  input wire logic [2:0] cfg_type,
  input wire logic [2:0] cfg_period,
  input wire logic cfg_attach,
  input wire logic cfg_is_lag,
  input wire logic cfg_port_in_lag,
  input wire logic cfg_cnt_clr,
  // endpoint health
  input wire logic mep_up,
  input wire logic rmep_up,
  input wire logic ccm_loss,
  // client link pin
  input wire logic client_link_up,
  // transmit stream
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  // receive stream
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  // status
  output logic attached,
  output logic attach_err,
  output logic remote_fault,
  output logic client_port_en,
  output logic [2:0] rx_level,
  output logic [15:0] tx_frames,
  output logic [15:0] rx_frames,
  output logic [15:0] tx_dci,
  output logic [15:0] rx_dci
);
  logic link_s;
  csf_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .din(client_link_up),
    .dout(link_s)
  );

  // one second tick
  logic [24:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick;
  always_comb begin
    tick = (tick_cnt_ff == 25'(csf_pkg::TICK_CYCLES - 1));
    nxt_tick_cnt = tick ? 25'h0 : tick_cnt_ff + 25'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tick_cnt_ff <= 25'h0;
    else tick_cnt_ff <= nxt_tick_cnt;
  end

  // attachment
  logic att_ff, nxt_att, aerr_ff, nxt_aerr;
  always_comb begin
    nxt_att = att_ff;
    nxt_aerr = 1'b0;
    if (cfg_attach) begin
      if (att_ff) nxt_aerr = 1'b1;
      else if (!cfg_is_lag && cfg_port_in_lag) nxt_aerr = 1'b1;
      else nxt_att = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      att_ff <= 1'b0;
      aerr_ff <= 1'b0;
    end else begin
      att_ff <= nxt_att;
      aerr_ff <= nxt_aerr;
    end
  end

  // transmit scheduling
  csf_pkg::csf_tx_state_type st_ff, nxt_st;
  logic [6:0] per_ff, nxt_per;
  logic [2:0] idx_ff, nxt_idx;
  logic busy_ff, nxt_busy;
  logic [2:0] ty_ff, nxt_ty;
  logic [8:0] lag_ff, nxt_lag;
  logic [6:0] per_sec;
  logic [8:0] per_half;
  logic eps_ok, fault, start;
  logic [7:0] byte_v;
  always_comb begin
    per_sec = (cfg_period == csf_pkg::PER_MIN) ? csf_pkg::SEC_PER_MIN : csf_pkg::SEC_PER_SEC;
    per_half = (cfg_period == csf_pkg::PER_MIN) ? csf_pkg::HALF_SEC_MIN : csf_pkg::HALF_SEC_SEC;
    eps_ok = mep_up && rmep_up && !ccm_loss;
    // lag down report after 3.5 intervals
    nxt_lag = lag_ff;
    if (link_s || !cfg_is_lag) nxt_lag = 9'h0;
    else if (tick && lag_ff < per_half) nxt_lag = lag_ff + 9'h2;
    fault = !link_s && (!cfg_is_lag || (lag_ff >= per_half));
    nxt_st = st_ff;
    nxt_per = per_ff;
    start = 1'b0;
    nxt_ty = ty_ff;
    case (st_ff)
      csf_pkg::TX_IDLE: begin
        nxt_per = 7'h0;
        if (fault) nxt_st = csf_pkg::TX_SEND;
      end
      csf_pkg::TX_SEND: begin
        if (!fault) nxt_st = csf_pkg::TX_CLEAR;
        else if (tick) begin
          if (per_ff == 7'h0) begin
            start = 1'b1;
            nxt_ty = cfg_type;
            nxt_per = per_sec - 7'h1;
          end else nxt_per = per_ff - 7'h1;
        end
      end
      csf_pkg::TX_CLEAR: begin
        if (!busy_ff) begin
          start = 1'b1;
          nxt_ty = csf_pkg::TYPE_DCI;
          nxt_st = csf_pkg::TX_IDLE;
        end
      end
      default: nxt_st = csf_pkg::TX_IDLE;
    endcase
    if (!cfg_tx_en || !att_ff || !eps_ok) start = 1'b0;
    nxt_busy = busy_ff;
    nxt_idx = idx_ff;
    if (start && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_idx = 3'h0;
    end else if (busy_ff && tx_ready) begin
      if (idx_ff == 3'(csf_pkg::PDU_LEN - 1)) nxt_busy = 1'b0;
      nxt_idx = idx_ff + 3'h1;
    end
    if (!eps_ok) nxt_busy = 1'b0;
    case (busy_ff && tx_ready ? idx_ff + 3'h1 : idx_ff)
      3'h0: byte_v = {cfg_level, csf_pkg::VERSION_VAL};
      3'h1: byte_v = csf_pkg::OPCODE_CSF;
      3'h2: byte_v = {1'b0, nxt_ty, cfg_period, 1'b0};
      3'h3: byte_v = csf_pkg::TLV_OFFSET_VAL;
      default: byte_v = csf_pkg::END_TLV_VAL;
    endcase
    if (start && !busy_ff) byte_v = {cfg_level, csf_pkg::VERSION_VAL};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= csf_pkg::TX_IDLE;
      per_ff <= 7'h0;
      idx_ff <= 3'h0;
      busy_ff <= 1'b0;
      ty_ff <= 3'h0;
      lag_ff <= 9'h0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      per_ff <= nxt_per;
      idx_ff <= nxt_idx;
      busy_ff <= nxt_busy;
      ty_ff <= nxt_ty;
      lag_ff <= nxt_lag;
      tx_data <= byte_v;
      tx_valid <= nxt_busy;
      tx_last <= nxt_busy && (nxt_idx == 3'(csf_pkg::PDU_LEN - 1));
    end
  end

  // receive parser
  logic [2:0] rpos_ff, nxt_rpos;
  logic [2:0] rlvl_ff, nxt_rlvl, rty_ff, nxt_rty, rper_ff, nxt_rper;
  logic rok_ff, nxt_rok, rf_ff, nxt_rf;
  logic pen_ff;
  logic [8:0] rto_ff, nxt_rto;
  logic [2:0] rlev_out_ff, nxt_rlev_out;
  logic [8:0] rhalf;
  logic acc, acc_dci;
  always_comb begin
    nxt_rpos = rpos_ff;
    nxt_rlvl = rlvl_ff;
    nxt_rty = rty_ff;
    nxt_rper = rper_ff;
    nxt_rok = rok_ff;
    acc = 1'b0;
    if (rx_valid) begin
      nxt_rpos = rx_last ? 3'h0 : ((rpos_ff == 3'h7) ? rpos_ff : rpos_ff + 3'h1);
      case (rpos_ff)
        3'h0: begin
          nxt_rlvl = rx_data[7:5];
          nxt_rok = 1'b1;
        end
        3'h1: if (rx_data != csf_pkg::OPCODE_CSF) nxt_rok = 1'b0;
        3'h2: begin
          nxt_rty = rx_data[6:4];
          nxt_rper = rx_data[3:1];
          if (rx_data[3:1] == csf_pkg::PER_INVALID) nxt_rok = 1'b0;
        end
        default: nxt_rok = rok_ff;
      endcase
      if (rx_last) acc = nxt_rok && (rpos_ff >= 3'h2);
    end
    acc_dci = acc && nxt_rty == csf_pkg::TYPE_DCI;
    rhalf = (rper_ff == csf_pkg::PER_MIN) ? csf_pkg::HALF_SEC_MIN : csf_pkg::HALF_SEC_SEC;
    nxt_rf = rf_ff;
    nxt_rto = rto_ff;
    nxt_rlev_out = acc ? nxt_rlvl : rlev_out_ff;
    if (acc) begin
      nxt_rto = 9'h0;
      nxt_rf = !acc_dci;
    end else if (rf_ff && tick) begin
      if (rto_ff + 9'h2 >= rhalf) nxt_rf = 1'b0;
      else nxt_rto = rto_ff + 9'h2;
    end
    if (ccm_loss) nxt_rf = 1'b0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rpos_ff <= 3'h0;
      rlvl_ff <= 3'h0;
      rty_ff <= 3'h0;
      rper_ff <= 3'h0;
      rok_ff <= 1'b0;
      rf_ff <= 1'b0;
      pen_ff <= 1'b1;
      rto_ff <= 9'h0;
      rlev_out_ff <= 3'h0;
    end else begin
      rpos_ff <= nxt_rpos;
      rlvl_ff <= nxt_rlvl;
      rty_ff <= nxt_rty;
      rper_ff <= nxt_rper;
      rok_ff <= nxt_rok;
      rf_ff <= nxt_rf;
      pen_ff <= !nxt_rf;
      rto_ff <= nxt_rto;
      rlev_out_ff <= nxt_rlev_out;
    end
  end

  // counters
  logic [15:0] ctf_ff, crf_ff, ctd_ff, crd_ff;
  logic [15:0] nxt_ctf, nxt_crf, nxt_ctd, nxt_crd;
  logic tx_done;
  always_comb begin
    tx_done = busy_ff && tx_ready && idx_ff == 3'(csf_pkg::PDU_LEN - 1);
    if (cfg_cnt_clr) begin
      nxt_ctf = csf_pkg::CNT_RESET;
      nxt_crf = csf_pkg::CNT_RESET;
      nxt_ctd = csf_pkg::CNT_RESET;
      nxt_crd = csf_pkg::CNT_RESET;
    end else begin
      nxt_ctf = ctf_ff + {15'h0, tx_done};
      nxt_crf = crf_ff + {15'h0, acc};
      nxt_ctd = ctd_ff + {15'h0, tx_done && ty_ff == csf_pkg::TYPE_DCI};
      nxt_crd = crd_ff + {15'h0, acc_dci};
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctf_ff <= csf_pkg::CNT_RESET;
      crf_ff <= csf_pkg::CNT_RESET;
      ctd_ff <= csf_pkg::CNT_RESET;
      crd_ff <= csf_pkg::CNT_RESET;
    end else begin
      ctf_ff <= nxt_ctf;
      crf_ff <= nxt_crf;
      ctd_ff <= nxt_ctd;
      crd_ff <= nxt_crd;
    end
  end

  assign attached = att_ff;
  assign attach_err = aerr_ff;
  assign remote_fault = rf_ff;
  assign client_port_en = pen_ff;
  assign rx_level = rlev_out_ff;
  assign tx_frames = ctf_ff;
  assign rx_frames = crf_ff;
  assign tx_dci = ctd_ff;
  assign rx_dci = crd_ff;
endmodule : csf_framer

// *** hdl/csf_pkg.sv ***
// Purpose: constants and types for the client signal fail framer
// Assumes: 25 MHz system clock, one-second tick generated inside
// Notes: pdu octet order is level/version, opcode, flags, tlv offset, end tlv
package csf_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  localparam logic [7:0] OPCODE_CSF = 8'h34;
  localparam logic [4:0] VERSION_VAL = 5'h00;
  localparam logic [7:0] TLV_OFFSET_VAL = 8'h00;
  localparam logic [7:0] END_TLV_VAL = 8'h00;
  localparam logic [2:0] TYPE_LOS = 3'h0;
  localparam logic [2:0] TYPE_FDI = 3'h1;
  localparam logic [2:0] TYPE_RDI = 3'h2;
  localparam logic [2:0] TYPE_DCI = 3'h3;
  localparam logic [2:0] PER_INVALID = 3'h0;
  localparam logic [2:0] PER_SEC = 3'h4;
  localparam logic [2:0] PER_MIN = 3'h6;
  localparam int unsigned FLAG_TYPE_LSB = 4;
  localparam int unsigned FLAG_PER_LSB = 1;
  // periods in seconds; timeout is 3.5 periods, kept in half-seconds
  localparam logic [6:0] SEC_PER_SEC = 7'h01;
  localparam logic [6:0] SEC_PER_MIN = 7'h3c;
  localparam logic [8:0] HALF_SEC_SEC = 9'h007;
  localparam logic [8:0] HALF_SEC_MIN = 9'h1a4;
  localparam int unsigned PDU_LEN = 5;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_CLEAR} csf_tx_state_type;
endpackage : csf_pkg

// *** hdl/csf_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous input level
// Notes: output changes when stages two and three agree
`timescale 1ns/1ps
module csf_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic [2:0] sh_ff;
  logic [2:0] nxt_sh;
  logic out_ff;
  logic nxt_out;

  always_comb begin
    nxt_sh = {sh_ff[1:0], din};
    nxt_out = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : out_ff;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_ff <= 3'h7;
      out_ff <= 1'b1;
    end else begin
      sh_ff <= nxt_sh;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;
endmodule : csf_sync

// *** test/csf_framer_assertions.sv ***
// Purpose: port checks on the framer
// Assumes: one clock, async active-low reset
// Notes: tx byte index kept in helper logic
`timescale 1ns/1ps
module csf_framer_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // inputs
  input wire logic cfg_tx_en,
  input wire logic cfg_attach,
  input wire logic cfg_is_lag,
  input wire logic cfg_port_in_lag,
  input wire logic cfg_cnt_clr,
  input wire logic mep_up,
  input wire logic rmep_up,
  input wire logic ccm_loss,
  input wire logic tx_ready,
  // outputs
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic attached,
  input wire logic attach_err,
  input wire logic remote_fault,
  input wire logic client_port_en,
  input wire logic [15:0] tx_frames,
  input wire logic [15:0] rx_frames,
  input wire logic [15:0] tx_dci,
  input wire logic [15:0] rx_dci
);
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  always_comb begin
    nxt_idx = idx_ff;
    if (!tx_valid) begin
      nxt_idx = 3'h0;
    end else if (tx_ready) begin
      nxt_idx = tx_last ? 3'h0 : idx_ff + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_ff <= 3'h0;
    end else begin
      idx_ff <= nxt_idx;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_err_pulse; attach_err |=> !attach_err; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("attach_err too long");
  property p_dup; cfg_attach && attached |=> attach_err && attached; endproperty
  a_dup: assert property (p_dup) else $error("second attach accepted");
  property p_lag; cfg_attach && !attached && !cfg_is_lag && cfg_port_in_lag
    |=> attach_err && !attached; endproperty
  a_lag: assert property (p_lag) else $error("lag member attached");
  property p_port; client_port_en != remote_fault; endproperty
  a_port: assert property (p_port) else $error("client port state wrong");
  property p_ccm; ccm_loss |=> !remote_fault && client_port_en; endproperty
  a_ccm: assert property (p_ccm) else $error("ccm loss kept port down");
  property p_clr; cfg_cnt_clr |=> (tx_frames | rx_frames | tx_dci | rx_dci) == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("counters not cleared");
  property p_gate; $rose(tx_valid) |-> $past(cfg_tx_en && mep_up && rmep_up && attached);
  endproperty
  a_gate: assert property (p_gate) else $error("pdu sent while disallowed");
  property p_opc; tx_valid && idx_ff == 3'h1 |-> tx_data == 8'h34; endproperty
  a_opc: assert property (p_opc) else $error("bad opcode");
  property p_tail; tx_valid && idx_ff[2] |-> tx_last && tx_data == 8'h00; endproperty
  a_tail: assert property (p_tail) else $error("bad end octet");
  property p_flag; tx_valid && idx_ff == 3'h2 |-> !tx_data[7] && !tx_data[0]; endproperty
  a_flag: assert property (p_flag) else $error("flag spare bits set");
  property p_off; tx_valid && idx_ff == 3'h3 |-> tx_data == 8'h00; endproperty
  a_off: assert property (p_off) else $error("bad tlv offset");
endmodule : csf_framer_assertions

bind csf_framer csf_framer_assertions u_chk (.clk, .resetn, .cfg_tx_en, .cfg_attach,
  .cfg_is_lag, .cfg_port_in_lag, .cfg_cnt_clr, .mep_up, .rmep_up, .ccm_loss, .tx_ready,
  .tx_data, .tx_valid, .tx_last, .attached, .attach_err, .remote_fault, .client_port_en,
  .tx_frames, .rx_frames, .tx_dci, .rx_dci);

// *** test/csf_framer_test.sv ***
// Purpose: self-checking bench for the framer
// Assumes: one-second tick too long to reach here
// Notes: attach, receive, counter and gating paths
`timescale 1ns/1ps
module csf_framer_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_tx_en = 1'b0, cfg_attach = 1'b0, cfg_is_lag = 1'b0, cfg_port_in_lag = 1'b0;
  logic cfg_cnt_clr = 1'b0, mep_up = 1'b1, rmep_up = 1'b1, ccm_loss = 1'b0;
  logic client_link_up = 1'b1, slow = 1'b0, seen;
  logic [2:0] cfg_level = 3'h5, cfg_type = 3'h0, cfg_period = 3'h4, rx_level;
  logic [7:0] tx_data, rx_data;
  logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, attached, attach_err;
  logic remote_fault, client_port_en;
  logic [15:0] tx_frames, rx_frames, tx_dci, rx_dci;
  int n_errors = 0, tests_run = 0;
  always #20 clk = ~clk;
  csf_framer dut (
    .clk(clk),
    .resetn(resetn),
    .cfg_tx_en(cfg_tx_en),
    .cfg_level(cfg_level),
    .cfg_type(cfg_type),
    .cfg_period(cfg_period),
    .cfg_attach(cfg_attach),
    .cfg_is_lag(cfg_is_lag),
    .cfg_port_in_lag(cfg_port_in_lag),
    .cfg_cnt_clr(cfg_cnt_clr),
    .mep_up(mep_up),
    .rmep_up(rmep_up),
    .ccm_loss(ccm_loss),
    .client_link_up(client_link_up),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_last(rx_last),
    .attached(attached),
    .attach_err(attach_err),
    .remote_fault(remote_fault),
    .client_port_en(client_port_en),
    .rx_level(rx_level),
    .tx_frames(tx_frames),
    .rx_frames(rx_frames),
    .tx_dci(tx_dci),
    .rx_dci(rx_dci)
  );
  csf_peer peer (
    .clk(clk),
    .slow(slow),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_last(rx_last),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic [39:0] mk(input logic [2:0] l, t, p, input logic [7:0] op);
    return {l, 5'h00, op, 1'b0, t, p, 1'b0, 16'h0000};
  endfunction : mk
  task automatic attach_pulse;
    cfg_attach = 1'b1;
    cyc(1);
    cfg_attach = 1'b0;
  endtask : attach_pulse
  task automatic t_attach;
    cfg_port_in_lag = 1'b1;
    attach_pulse();
    chk("attach_err", 1, attach_err);
    chk("attached", 0, attached);
    cfg_port_in_lag = 1'b0;
    cyc(1);
    attach_pulse();
    chk("attached", 1, attached);
    cyc(1);
    attach_pulse();
    chk("attach_err", 1, attach_err);
    $display("test attach done");
  endtask : t_attach
  task automatic t_rx;
    for (int t = 0; t < 3; t++) begin
      peer.send(mk(3'(t + 2), 3'(t), t[0] ? 3'h6 : 3'h4, 8'h34), 1'b0);
      cyc(2);
      chk("remote_fault", 1, remote_fault);
      chk("client_port_en", 0, client_port_en);
      chk("rx_level", 16'(t + 2), rx_level);
      peer.send(mk(3'h1, 3'h3, 3'h4, 8'h34), 1'b0);
      cyc(2);
      chk("remote_fault", 0, remote_fault);
    end
    chk("rx_dci", 3, rx_dci);
    chk("rx_frames", 6, rx_frames);
    $display("test receive done");
  endtask : t_rx
  task automatic t_drop;
    peer.send(mk(3'h1, 3'h0, 3'h4, 8'h35), 1'b0);
    cyc(2);
    chk("remote_fault", 0, remote_fault);
    peer.send(mk(3'h1, 3'h0, 3'h0, 8'h34), 1'b0);
    cyc(2);
    chk("remote_fault", 0, remote_fault);
    peer.send(mk(3'h1, 3'h0, 3'h4, 8'h34), 1'b1);
    cyc(2);
    chk("remote_fault", 0, remote_fault);
    $display("test drop done");
  endtask : t_drop
  task automatic t_ccm;
    peer.send(mk(3'h1, 3'h1, 3'h4, 8'h34), 1'b0);
    cyc(2);
    chk("remote_fault", 1, remote_fault);
    ccm_loss = 1'b1;
    cyc(2);
    chk("client_port_en", 1, client_port_en);
    ccm_loss = 1'b0;
    cfg_cnt_clr = 1'b1;
    cyc(1);
    cfg_cnt_clr = 1'b0;
    chk("counters", 0, rx_frames | rx_dci | tx_frames | tx_dci);
    $display("test ccm and clear done");
  endtask : t_ccm
  task automatic watch(input int n);
    repeat (n) begin
      cyc(1);
      seen = seen | tx_valid;
    end
  endtask : watch
  task automatic t_notx;
    slow = 1'b1;
    for (int k = 0; k < 2; k++) begin
      seen = 1'b0;
      client_link_up = 1'b0;
      watch(10);
      client_link_up = 1'b1;
      watch(20);
      chk("tx_valid", 0, seen);
      cfg_tx_en = 1'b1;
      rmep_up = 1'b0;
    end
    $display("test gating done");
  endtask : t_notx
  task automatic t_dci;
    logic [7:0] got [5];
    logic [4:0] lasts;
    int n;
    n = 0;
    lasts = 5'h00;
    rmep_up = 1'b1;
    client_link_up = 1'b0;
    cyc(10);
    client_link_up = 1'b1;
    repeat (40) begin
      if (tx_valid && tx_ready && n < 5) begin
        got[n] = tx_data;
        lasts[n] = tx_last;
        n++;
      end
      cyc(1);
    end
    if (n != 5) begin
      chk("tx byte count", 5, 16'(n));
      stop_test();
    end
    chk("tx level octet", {8'h00, cfg_level, 5'h00}, {8'h00, got[0]});
    chk("tx opcode", 16'h0034, {8'h00, got[1]});
    chk("tx flags", 16'h0038, {8'h00, got[2]});
    chk("tx tlv offset", 16'h0000, {8'h00, got[3]});
    chk("tx end tlv", 16'h0000, {8'h00, got[4]});
    chk("tx_last", 16'h0010, {11'h000, lasts});
    chk("tx_frames", 1, tx_frames);
    chk("tx_dci", 1, tx_dci);
    $display("test dci done");
  endtask : t_dci
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    cyc(2);
    resetn = 1'b1;
    chk("client_port_en", 1, client_port_en);
    t_attach();
    t_rx();
    t_drop();
    t_ccm();
    t_notx();
    t_dci();
    stop_test();
  end
endmodule : csf_framer_test

// *** test/csf_peer.sv ***
// Purpose: peer endpoint feeding the receive stream
// Assumes: tasks entered just after a rising edge
// Notes: idle data shows the inverse of the last byte
`timescale 1ns/1ps
module csf_peer (
  // clock and mode
  input wire logic clk,
  input wire logic slow,
  // streams
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic tx_valid,
  output logic tx_ready
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  always @(posedge clk) tx_ready <= !slow || !tx_ready;
  task automatic send(input logic [39:0] pdu, input logic cut);
    for (int i = 0; i < (cut ? 2 : 5); i++) begin
      rx_data = pdu[39 - 8 * i -: 8];
      rx_valid = 1'b1;
      rx_last = (i == (cut ? 1 : 4));
      @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask : send
endmodule : csf_peer
